// file: common/pae_pkg.sv
package pae_pkg;
    localparam int unsigned SYS_CLK_HZ     = 25_000_000;
    localparam int unsigned DELAY_UNIT_S   = 1;
    localparam int unsigned CYCLES_PER_SEC = DELAY_UNIT_S * SYS_CLK_HZ;

    localparam int VAL_W   = 16;
    localparam int CALC_W  = 18;
    localparam int TYPE_W  = 5;
    localparam int DLY_W   = 10;
    localparam int HYS_W   = 14;
    localparam int RAW_W   = 16;

    localparam logic signed [CALC_W-1:0] PV_MIN = -18'sd19999;
    localparam logic signed [CALC_W-1:0] PV_MAX = 18'sd32400;
    localparam logic [DLY_W-1:0]  DELAY_MAX_S   = 10'h3e7;
    localparam logic [HYS_W-1:0]  HYS_MIN       = 14'h0001;
    localparam logic [HYS_W-1:0]  HYS_MAX       = 14'h270f;

    localparam logic [TYPE_W-1:0] TYPE_OFF       = 5'h00;
    localparam logic [TYPE_W-1:0] TYPE_DEV_OUT   = 5'h01;
    localparam logic [TYPE_W-1:0] TYPE_DEV_UP    = 5'h02;
    localparam logic [TYPE_W-1:0] TYPE_DEV_LO    = 5'h03;
    localparam logic [TYPE_W-1:0] TYPE_DEV_IN    = 5'h04;
    localparam logic [TYPE_W-1:0] TYPE_DEV_OUT_S = 5'h05;
    localparam logic [TYPE_W-1:0] TYPE_DEV_UP_S  = 5'h06;
    localparam logic [TYPE_W-1:0] TYPE_DEV_LO_S  = 5'h07;
    localparam logic [TYPE_W-1:0] TYPE_ABS_UP    = 5'h08;
    localparam logic [TYPE_W-1:0] TYPE_ABS_LO    = 5'h09;
    localparam logic [TYPE_W-1:0] TYPE_ABS_UP_S  = 5'h0a;
    localparam logic [TYPE_W-1:0] TYPE_ABS_LO_S  = 5'h0b;
    localparam logic [TYPE_W-1:0] TYPE_LOOP_BRK  = 5'h0c;
    localparam logic [TYPE_W-1:0] TYPE_RATE      = 5'h0d;
    localparam logic [TYPE_W-1:0] TYPE_SP_UP     = 5'h0e;
    localparam logic [TYPE_W-1:0] TYPE_SP_LO     = 5'h0f;
    localparam logic [TYPE_W-1:0] TYPE_MV_UP     = 5'h10;
    localparam logic [TYPE_W-1:0] TYPE_MV_LO     = 5'h11;
    localparam logic [TYPE_W-1:0] TYPE_DEFAULT   = TYPE_DEV_UP;

    localparam logic STANDBY_RESET = 1'b1;
endpackage

// file: src/process_alarm_evaluator.sv
`timescale 1ns/10ps
module process_alarm_evaluator
    import pae_pkg::*;
#(
    parameter int          NUM_CH    = 3,
    parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC
) (
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    input  wire logic                               sampleTick,
    input  wire logic        [RAW_W-1:0]            rawMeasure,
    input  wire logic signed [VAL_W-1:0]            scaleLow,
    input  wire logic signed [VAL_W-1:0]            scaleHigh,
    input  wire logic        [1:0]                  decimalPos,
    input  wire logic signed [VAL_W-1:0]            setPoint,
    input  wire logic                               setPointChanged,
    input  wire logic signed [VAL_W-1:0]            manipulatedValue,
    input  wire logic signed [VAL_W-1:0]            heatMv,
    input  wire logic signed [VAL_W-1:0]            coolMv,
    input  wire logic                               heatCoolMode,
    input  wire logic                               loopBreakAlarm,
    input  wire logic                               rateAlarm,
    input  wire logic                               heaterFaultAlarm,
    input  wire logic                               heaterMonitorFitted,
    input  wire logic                               assignAlarm1,
    input  wire logic                               typeWrite,
    input  wire logic        [NUM_CH-1:0][TYPE_W-1:0] typeWriteData,
    input  wire logic        [NUM_CH-1:0][VAL_W-1:0]  alarmValue,
    input  wire logic        [NUM_CH-1:0][VAL_W-1:0]  upperDev,
    input  wire logic        [NUM_CH-1:0][VAL_W-1:0]  lowerDev,
    input  wire logic        [NUM_CH-1:0][HYS_W-1:0]  hysteresis,
    input  wire logic        [NUM_CH-1:0][DLY_W-1:0]  onDelay,
    input  wire logic        [NUM_CH-1:0][DLY_W-1:0]  offDelay,
    output logic signed      [VAL_W-1:0]            processValue,
    output logic             [1:0]                  decimalPoint,
    output logic             [NUM_CH-1:0][TYPE_W-1:0] alarmType,
    output logic             [NUM_CH-1:0]           alarmOut
);
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);

    function automatic logic pae_eval(
        input logic [TYPE_W-1:0]        t,
        input logic signed [CALC_W-1:0] pv,
        input logic signed [CALC_W-1:0] sp,
        input logic signed [CALC_W-1:0] mvUp,
        input logic signed [CALC_W-1:0] mvLo,
        input logic signed [CALC_W-1:0] x,
        input logic signed [CALC_W-1:0] up,
        input logic signed [CALC_W-1:0] lo,
        input logic signed [CALC_W-1:0] h
    );
        logic r;
        r = 1'b0;
        case (t)
            TYPE_DEV_OUT, TYPE_DEV_OUT_S: r = (pv > sp + up - h) || (pv < sp - lo + h);
            TYPE_DEV_UP, TYPE_DEV_UP_S:   r = (pv - sp >= x - h);
            TYPE_DEV_LO, TYPE_DEV_LO_S:   r = (sp - pv >= x - h);
            TYPE_DEV_IN:                  r = (pv >= sp - lo - h) && (pv <= sp + up + h);
            TYPE_ABS_UP, TYPE_ABS_UP_S:   r = (pv > x - h);
            TYPE_ABS_LO, TYPE_ABS_LO_S:   r = (pv < x + h);
            TYPE_SP_UP:                   r = (sp > x - h);
            TYPE_SP_LO:                   r = (sp < x + h);
            TYPE_MV_UP:                   r = (mvUp > x - h);
            TYPE_MV_LO:                   r = (mvLo < x + h);
            default:                      r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic pae_has_standby(input logic [TYPE_W-1:0] t);
        return (t == TYPE_DEV_OUT_S) || (t == TYPE_DEV_UP_S) || (t == TYPE_DEV_LO_S) ||
               (t == TYPE_ABS_UP_S) || (t == TYPE_ABS_LO_S);
    endfunction

    // scaling: raw full scale maps onto low..high, then clamped to the legal span
    logic signed [CALC_W-1:0]   scaleSpan;
    logic signed [CALC_W+RAW_W:0] scaleProd;
    logic signed [CALC_W-1:0]   scaledRaw;
    logic signed [CALC_W-1:0]   scaledClamp;
    logic signed [VAL_W-1:0]    processValue_r;
    logic        [1:0]          decimalPoint_r;
    // the reset pv is no measurement, so no alarm is judged before the first sample
    logic                       pvValid_r;

    assign scaleSpan   = CALC_W'(scaleHigh) - CALC_W'(scaleLow);
    assign scaleProd   = (CALC_W+RAW_W+1)'(scaleSpan) * $signed({1'b0, rawMeasure});
    assign scaledRaw   = CALC_W'(scaleLow) + CALC_W'(scaleProd >>> RAW_W);
    assign scaledClamp = (scaledRaw < PV_MIN) ? PV_MIN :
                         (scaledRaw > PV_MAX) ? PV_MAX : scaledRaw;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            processValue_r <= '0;
            decimalPoint_r <= 2'h0;
            pvValid_r      <= 1'b0;
        end else if (sampleTick) begin
            processValue_r <= VAL_W'(scaledClamp);
            decimalPoint_r <= decimalPos;
            pvValid_r      <= 1'b1;
        end
    end
    assign processValue = processValue_r;
    assign decimalPoint = decimalPoint_r;

    // one shared seconds tick keeps the per-channel delay counters narrow
    logic [SEC_W-1:0] secCnt_r;
    logic             secTick_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            secCnt_r  <= '0;
            secTick_r <= 1'b0;
        end else begin
            secCnt_r  <= (secCnt_r == SEC_LAST) ? '0 : secCnt_r + 1'b1;
            secTick_r <= (secCnt_r == SEC_LAST);
        end
    end

    wire logic signed [CALC_W-1:0] pvC   = CALC_W'(processValue_r);
    wire logic signed [CALC_W-1:0] spC   = CALC_W'(setPoint);
    wire logic signed [CALC_W-1:0] mvUpC = heatCoolMode ? CALC_W'(heatMv)
                                                        : CALC_W'(manipulatedValue);
    wire logic signed [CALC_W-1:0] mvLoC = heatCoolMode ? CALC_W'(coolMv)
                                                        : CALC_W'(manipulatedValue);
    wire logic routeHeater = heaterMonitorFitted && !assignAlarm1;

    logic [NUM_CH-1:0] rawAlarm_r;
    logic [NUM_CH-1:0] standby_r;

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            logic [TYPE_W-1:0]        type_r;
            logic [DLY_W-1:0]         dlyCnt_r;
            logic                     out_r;
            logic [HYS_W-1:0]         hysEff;
            logic signed [CALC_W-1:0] hysHeld;
            logic signed [CALC_W-1:0] upC;
            logic signed [CALC_W-1:0] loC;
            logic                     cond;
            logic                     overlap;
            logic                     typeOk;
            logic                     rawNxt;
            logic [DLY_W-1:0]         dlyLim;
            logic [DLY_W-1:0]         dlySel;

            // hysteresis below one tenth or above 999.9 is held at the limit
            assign hysEff  = (hysteresis[c] < HYS_MIN) ? HYS_MIN :
                             (hysteresis[c] > HYS_MAX) ? HYS_MAX : hysteresis[c];
            assign hysHeld = rawAlarm_r[c] ? CALC_W'({1'b0, hysEff}) : '0;
            assign upC     = CALC_W'(upperDev[c]);
            assign loC     = CALC_W'(lowerDev[c]);
            assign cond    = pae_eval(type_r, pvC, spC, mvUpC, mvLoC,
                                      CALC_W'($signed(alarmValue[c])), upC, loC, hysHeld);
            assign overlap = (type_r == TYPE_DEV_OUT_S) &&
                             (upC + loC <= CALC_W'({hysEff, 1'b0}));
            // loop break is refused on every channel but the first
            assign typeOk  = !(typeWriteData[c] == TYPE_LOOP_BRK && c != 0) &&
                             (typeWriteData[c] <= TYPE_MV_LO);
            assign rawNxt  = (c == 0 && routeHeater)     ? heaterFaultAlarm :
                             (type_r == TYPE_LOOP_BRK)   ? (c == 0) && loopBreakAlarm :
                             (type_r == TYPE_RATE)       ? rateAlarm :
                             overlap                     ? 1'b0 :
                             (pae_has_standby(type_r) && standby_r[c]) ? 1'b0 :
                             cond;
            assign dlySel  = rawAlarm_r[c] ? onDelay[c] : offDelay[c];
            assign dlyLim  = (dlySel > DELAY_MAX_S) ? DELAY_MAX_S : dlySel;

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    type_r <= TYPE_DEFAULT;
                end else if (typeWrite && typeOk) begin
                    type_r <= typeWriteData[c];
                end
            end

            // a set point change re-arms standby; arming wins over release
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    standby_r[c] <= STANDBY_RESET;
                end else if (setPointChanged) begin
                    standby_r[c] <= 1'b1;
                end else if (sampleTick && pvValid_r && !cond) begin
                    standby_r[c] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    rawAlarm_r[c] <= 1'b0;
                end else if (sampleTick && pvValid_r) begin
                    rawAlarm_r[c] <= rawNxt;
                end
            end

            // counter only runs while raw differs from output, so a revert restarts it
            // a nonzero delay needs one tick more, as the first may land right after the change
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    dlyCnt_r <= '0;
                    out_r    <= 1'b0;
                end else if (rawAlarm_r[c] == out_r) begin
                    dlyCnt_r <= '0;
                end else if (dlyLim == '0 || dlyCnt_r > dlyLim) begin
                    out_r    <= rawAlarm_r[c];
                    dlyCnt_r <= '0;
                end else if (secTick_r) begin
                    dlyCnt_r <= dlyCnt_r + 1'b1;
                end
            end
            assign alarmOut[c]  = out_r;
            assign alarmType[c] = type_r;

            a_type_off: assert property (@(posedge sys_clk) disable iff (rst)
                (sampleTick && type_r == TYPE_OFF && !(c == 0 && routeHeater))
                |=> !rawAlarm_r[c]) else $error("disabled channel raised alarm");
            a_dev_upper: assert property (@(posedge sys_clk) disable iff (rst)
                (sampleTick && type_r == TYPE_DEV_UP && !(c == 0 && routeHeater) &&
                 pvValid_r && pvC - spC >= CALC_W'($signed(alarmValue[c]))) |=> rawAlarm_r[c])
                else $error("deviation upper alarm missed");
            a_standby_hold: assert property (@(posedge sys_clk) disable iff (rst)
                (sampleTick && standby_r[c] && pae_has_standby(type_r) &&
                 !(c == 0 && routeHeater)) |=> !rawAlarm_r[c])
                else $error("alarm raised during standby");
            a_overlap_off: assert property (@(posedge sys_clk) disable iff (rst)
                (sampleTick && overlap && !(c == 0 && routeHeater)) |=> !rawAlarm_r[c])
                else $error("overlapping bands raised alarm");
            a_zero_delay: assert property (@(posedge sys_clk) disable iff (rst)
                ($rose(rawAlarm_r[c]) && onDelay[c] == '0) |=> out_r)
                else $error("zero on delay not immediate");
            a_on_delay_wait: assert property (@(posedge sys_clk) disable iff (rst)
                ($rose(rawAlarm_r[c]) && !out_r && onDelay[c] != '0) |=> !out_r [*2])
                else $error("output switched before on delay");
            a_type_default: assert property (@(posedge sys_clk)
                rst |=> type_r == TYPE_DEFAULT) else $error("type not default after reset");
            if (c != 0) begin : g_nolba
                a_lba_refused: assert property (@(posedge sys_clk) disable iff (rst)
                    (typeWrite && typeWriteData[c] == TYPE_LOOP_BRK) |=> type_r != TYPE_LOOP_BRK)
                    else $error("loop break accepted off channel one");
            end
        end
    endgenerate

    sequence s_heater_sample;
        sampleTick && pvValid_r && routeHeater;
    endsequence
    sequence s_heater_follow;
        rawAlarm_r[0] == $past(heaterFaultAlarm);
    endsequence
    a_heater_route: assert property (@(posedge sys_clk) disable iff (rst)
        s_heater_sample |=> s_heater_follow) else $error("heater fault not routed");
    a_pv_range: assert property (@(posedge sys_clk) disable iff (rst)
        CALC_W'(processValue_r) >= PV_MIN && CALC_W'(processValue_r) <= PV_MAX)
        else $error("process value out of span");
endmodule

// file: sim/pae_core_model.sv
`timescale 1ns/10ps
module pae_core_model
    import pae_pkg::*;
#(
    parameter int PERIOD = 4
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic        [RAW_W-1:0] rawReq,
    input  wire logic signed [VAL_W-1:0] spReq,
    input  wire logic signed [VAL_W-1:0] mvReq,
    input  wire logic                    hcReq,
    input  wire logic                    lbReq,
    input  wire logic                    rateReq,
    output logic                         sampleTick,
    output logic             [RAW_W-1:0] rawMeasure,
    output logic signed      [VAL_W-1:0] setPoint,
    output logic signed      [VAL_W-1:0] manipulatedValue,
    output logic signed      [VAL_W-1:0] heatMv,
    output logic signed      [VAL_W-1:0] coolMv,
    output logic                         loopBreakAlarm,
    output logic                         rateAlarm
);
    int   cnt_r = 0;
    logic tickNxt;
    assign tickNxt = !rst && cnt_r == PERIOD - 1;
    initial begin
        sampleTick = 1'b0;
        {rawMeasure, setPoint, manipulatedValue, heatMv, coolMv} = '0;
        {loopBreakAlarm, rateAlarm} = 2'b00;
    end
    // values move only together with the strobe, as a real core would
    always @(negedge sys_clk) begin
        // step past the bench's own falling-edge writes so requests are read settled
        #1;
        cnt_r <= tickNxt || rst ? 0 : cnt_r + 1;
        sampleTick <= tickNxt;
        if (tickNxt) begin
            rawMeasure <= rawReq;
            setPoint <= spReq;
            // the unused mv carries a decoy so a wrong pick shows up
            manipulatedValue <= hcReq ? ~mvReq : mvReq;
            heatMv <= hcReq ? mvReq : ~mvReq;
            coolMv <= hcReq ? mvReq : ~mvReq;
            loopBreakAlarm <= lbReq;
            rateAlarm <= rateReq;
        end
    end
endmodule

// file: sim/tb_process_alarm_evaluator.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_process_alarm_evaluator
    import pae_pkg::*;
;
    typedef struct { int kind; logic [17:0] val; } pae_note_t;
    localparam int SEC = 10;
    logic                          sys_clk = 1'b0;
    logic                          rst = 1'b1;
    logic                          setPointChanged = 1'b0;
    logic                          heaterFaultAlarm = 1'b0;
    logic                          heaterMonitorFitted = 1'b0;
    logic                          assignAlarm1 = 1'b0;
    logic                          typeWrite = 1'b0;
    logic                          heatCoolMode = 1'b0;
    logic                          lbReq = 1'b0;
    logic                          rateReq = 1'b0;
    logic        [RAW_W-1:0]       rawReq = 16'h0fa0;
    logic signed [VAL_W-1:0]       spReq = 16'h03e8;
    logic signed [VAL_W-1:0]       mvReq = 16'h0000;
    logic signed [VAL_W-1:0]       scaleLow = 16'h0000;
    logic signed [VAL_W-1:0]       scaleHigh = 16'h4000;
    logic        [1:0]             decimalPos = 2'h0;
    logic        [2:0][TYPE_W-1:0] typeWriteData = '0;
    logic        [2:0][VAL_W-1:0]  alarmValue = '0;
    logic        [2:0][VAL_W-1:0]  upperDev = {3{16'h0064}};
    logic        [2:0][VAL_W-1:0]  lowerDev = {3{16'h0064}};
    logic        [2:0][HYS_W-1:0]  hysteresis = {3{14'h0001}};
    logic        [2:0][DLY_W-1:0]  onDelay = '0;
    logic        [2:0][DLY_W-1:0]  offDelay = '0;
    logic                          sampleTick, loopBreakAlarm, rateAlarm;
    logic        [RAW_W-1:0]       rawMeasure;
    logic signed [VAL_W-1:0]       setPoint, manipulatedValue, heatMv, coolMv, processValue;
    logic        [1:0]             decimalPoint;
    logic        [2:0][TYPE_W-1:0] alarmType;
    logic        [2:0]             alarmOut;
    int                            errors = 0;
    int                            checked = 0;
    logic        [31:0]            seed = 32'h3095;
    pae_note_t                     notes[$];
    event                          chkEv;

    always #20 sys_clk = ~sys_clk;

    pae_core_model core_u (.sys_clk(sys_clk), .rst(rst), .rawReq(rawReq), .spReq(spReq),
        .mvReq(mvReq), .hcReq(heatCoolMode), .lbReq(lbReq), .rateReq(rateReq),
        .sampleTick(sampleTick), .rawMeasure(rawMeasure), .setPoint(setPoint),
        .manipulatedValue(manipulatedValue), .heatMv(heatMv), .coolMv(coolMv),
        .loopBreakAlarm(loopBreakAlarm), .rateAlarm(rateAlarm));

    process_alarm_evaluator #(.NUM_CH(3), .SEC_CYCLES(SEC)) dut_u (.sys_clk(sys_clk),
        .rst(rst), .sampleTick(sampleTick), .rawMeasure(rawMeasure), .scaleLow(scaleLow),
        .scaleHigh(scaleHigh), .decimalPos(decimalPos), .setPoint(setPoint),
        .setPointChanged(setPointChanged), .manipulatedValue(manipulatedValue),
        .heatMv(heatMv), .coolMv(coolMv), .heatCoolMode(heatCoolMode),
        .loopBreakAlarm(loopBreakAlarm), .rateAlarm(rateAlarm),
        .heaterFaultAlarm(heaterFaultAlarm), .heaterMonitorFitted(heaterMonitorFitted),
        .assignAlarm1(assignAlarm1), .typeWrite(typeWrite), .typeWriteData(typeWriteData),
        .alarmValue(alarmValue), .upperDev(upperDev), .lowerDev(lowerDev),
        .hysteresis(hysteresis), .onDelay(onDelay), .offDelay(offDelay),
        .processValue(processValue), .decimalPoint(decimalPoint), .alarmType(alarmType),
        .alarmOut(alarmOut));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic expect_val(input int kind, input logic [17:0] val);
        notes.push_back('{kind, val});
        ->chkEv;
    endtask

    always @(chkEv) begin : watch_outputs
        pae_note_t n;
        n = notes.pop_front();
        case (n.kind)
            0: `CHK({17'h0, alarmOut[0]}, n.val)
            1: `CHK({3'h0, alarmType}, n.val)
            3: `CHK({15'h0, alarmOut}, n.val)
            default: `CHK({decimalPoint, processValue}, n.val)
        endcase
    end

    task automatic set_types(input logic [TYPE_W-1:0] t2, t1, t0);
        typeWriteData = {t2, t1, t0};
        typeWrite = 1'b1;
        cyc(1);
        typeWrite = 1'b0;
    endtask

    // start each case from reset, which clears the raw alarm, so no hysteresis is carried in
    task automatic row(input logic [TYPE_W-1:0] t, input int pv, x, mv,
                       input logic hc, lb, rt, ex);
        rawReq = 16'h0fa0;
        alarmValue[0] = '0;
        {mvReq, heatCoolMode, lbReq, rateReq} = '0;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        set_types(TYPE_DEFAULT, TYPE_DEFAULT, t);
        rawReq = 16'(pv * 4);
        alarmValue[0] = 16'(x);
        mvReq = 16'(mv);
        {heatCoolMode, lbReq, rateReq} = {hc, lb, rt};
        cyc(16);
        expect_val(0, {17'h0, ex});
    endtask

    task automatic give_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        errors++;
        give_verdict();
    end

    initial begin
        cyc(16);
        rst = 1'b0;
        cyc(1);
        expect_val(1, 18'h00842);
        set_types(TYPE_LOOP_BRK, 5'h12, TYPE_DEV_OUT_S);
        cyc(1);
        expect_val(1, 18'h00845);
        $display("test type write done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            rawReq = seed[15:0];
            decimalPos = seed[17:16];
            cyc(12);
            expect_val(2, {seed[17:16], 2'h0, seed[15:2]});
        end
        scaleHigh = 16'h7fff;
        rawReq = 16'hffff;
        cyc(12);
        expect_val(2, {decimalPos, 16'h7e90});
        scaleLow = 16'h8000;
        rawReq = 16'h0000;
        cyc(12);
        expect_val(2, {decimalPos, 16'hb1e1});
        {scaleLow, scaleHigh} = {16'h0000, 16'h4000};
        $display("test scaling done");
        row(TYPE_OFF, 2000, 10, 0, 0, 0, 0, 0);
        row(TYPE_DEV_OUT, 1200, 0, 0, 0, 0, 0, 1);
        row(TYPE_DEV_UP, 1050, 50, 0, 0, 0, 0, 1);
        row(TYPE_DEV_UP, 1049, 50, 0, 0, 0, 0, 0);
        row(TYPE_DEV_UP, 960, -50, 0, 0, 0, 0, 1);
        row(TYPE_DEV_LO, 950, 50, 0, 0, 0, 0, 1);
        row(TYPE_DEV_IN, 1100, 0, 0, 0, 0, 0, 1);
        row(TYPE_ABS_UP, 1001, 1000, 0, 0, 0, 0, 1);
        row(TYPE_ABS_LO, 999, 1000, 0, 0, 0, 0, 1);
        row(TYPE_LOOP_BRK, 1000, 0, 0, 0, 1, 0, 1);
        row(TYPE_RATE, 1000, 0, 0, 0, 0, 1, 1);
        row(TYPE_SP_UP, 1000, 999, 0, 0, 0, 0, 1);
        row(TYPE_SP_LO, 1000, 1000, 0, 0, 0, 0, 0);
        row(TYPE_MV_UP, 1000, 50, 60, 1, 0, 0, 1);
        row(TYPE_MV_LO, 1000, 50, 40, 0, 0, 0, 1);
        hysteresis[0] = 14'h0064;
        row(TYPE_DEV_OUT_S, 1200, 0, 0, 0, 0, 0, 0);
        hysteresis[0] = 14'h0001;
        $display("test type table done");
        row(TYPE_DEV_LO_S, 900, 50, 0, 0, 0, 0, 0);
        row(TYPE_ABS_UP_S, 1100, 1000, 0, 0, 0, 0, 0);
        row(TYPE_ABS_LO_S, 900, 1000, 0, 0, 0, 0, 0);
        row(TYPE_DEV_UP_S, 1100, 50, 0, 0, 0, 0, 0);
        rawReq = 16'h0fa0;
        cyc(16);
        rawReq = 16'h1130;
        cyc(16);
        expect_val(0, 18'h00001);
        setPointChanged = 1'b1;
        cyc(1);
        setPointChanged = 1'b0;
        cyc(16);
        expect_val(0, 18'h00000);
        $display("test standby done");
        {onDelay[0], offDelay[0]} = {10'h003, 10'h003};
        row(TYPE_ABS_UP, 1100, 1000, 0, 0, 0, 0, 0);
        cyc(40);
        expect_val(0, 18'h00001);
        // short dips must not add up towards the off delay
        rawReq = 16'h0e10;
        cyc(12);
        rawReq = 16'h1130;
        cyc(12);
        rawReq = 16'h0e10;
        cyc(24);
        rawReq = 16'h1130;
        cyc(20);
        expect_val(0, 18'h00001);
        {onDelay[0], offDelay[0]} = '0;
        $display("test delays done");
        row(TYPE_OFF, 1000, 0, 0, 0, 0, 0, 0);
        {heaterMonitorFitted, heaterFaultAlarm} = 2'b11;
        cyc(16);
        expect_val(3, 18'h00007);
        assignAlarm1 = 1'b1;
        cyc(16);
        expect_val(3, 18'h00006);
        $display("test heater route done");
        cyc(2);
        give_verdict();
    end
endmodule
